// [core/tmcc_pkg.sv]
// Constants, register map and carrier types of the 16-bit timer control block
package tmcc_pkg;

  // ==========================================================================
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_CTRL_A = 8'h00;  // timer_control_a
  localparam logic [7:0] OFS_CTRL_B = 8'h04;  // timer_control_b
  localparam logic [7:0] OFS_FORCE  = 8'h08;  // force_compare_strobe
  localparam logic [7:0] OFS_COUNT  = 8'h0c;  // counter_value
  localparam logic [7:0] OFS_CMP_A  = 8'h10;  // compare_value_a
  localparam logic [7:0] OFS_CMP_B  = 8'h14;  // compare_value_b
  localparam logic [7:0] OFS_CAPT   = 8'h18;  // capture_value_reg
  localparam logic [7:0] OFS_FLAGS  = 8'h1c;  // Event flags, write one to clear

  // ==========================================================================
  // Field positions
  localparam int CA_ACT_A_LSB = 6;  // output_action_sel, channel A
  localparam int CA_ACT_B_LSB = 4;  // output_action_sel, channel B
  localparam int CB_FILT_BIT  = 7;  // capture_filter_en
  localparam int CB_EDGE_BIT  = 6;  // capture_edge_sel
  localparam int CB_RSVD_BIT  = 5;  // Reserved, reads zero
  localparam int CB_WGMH_LSB  = 3;  // Upper mode bits
  localparam int FC_A_BIT     = 7;  // force_match_a
  localparam int FC_B_BIT     = 6;  // force_match_b
  localparam int FL_CAPT      = 5;  // capture_flag
  localparam int FL_CMP_B     = 2;  // Compare B match flag
  localparam int FL_CMP_A     = 1;  // Compare A match flag
  localparam int FL_OVF       = 0;  // overflow_flag

  // ==========================================================================
  // Reset values and fixed TOP values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] TOP_8B   = 16'h00ff;
  localparam logic [15:0] TOP_9B   = 16'h01ff;
  localparam logic [15:0] TOP_10B  = 16'h03ff;
  localparam logic [3:0]  WGM_RSVD = 4'hd;

  // Clock source codes
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FAL = 3'h6;
  localparam logic [2:0] CS_EXT_RIS = 3'h7;

  // Output action codes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TGL = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Counting sequence classes
  typedef enum logic [2:0] {
    K_NORMAL = 3'b000,
    K_CTC    = 3'b001,
    K_FAST   = 3'b011,
    K_PC     = 3'b010,
    K_PFC    = 3'b110
  } tmcc_kind_e;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tmcc_apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tmcc_apb_rsp_s;

  // Waveform outputs with their enables
  typedef struct packed {
    logic wave_out_a;
    logic wave_out_a_en;
    logic wave_out_b;
    logic wave_out_b_en;
  } tmcc_wave_s;

  // Whole block state
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [15:0] cnt;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b_buf;
    logic [15:0] cmp_b;
    logic [15:0] capt;
    logic [5:0]  flags;
    logic        down;
    logic        wave_a;
    logic        wave_b;
    logic        ext_prev;
    logic [3:0]  cap_shift;
    logic        cap_filt;
    logic        cap_prev;
    logic [9:0]  psc;
    logic [31:0] prdata;
  } tmcc_state_s;

endpackage : tmcc_pkg

// [core/tmcc_timer16_ctl.sv]
// Mode decode, clock select, capture and forced-compare logic of a 16-bit timer
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module tmcc_timer16_ctl #(
  parameter int PSC_W = 10  // Prescaler width, must reach the largest divisor
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire tmcc_pkg::tmcc_apb_req_s apb_req,
  output      tmcc_pkg::tmcc_apb_rsp_s apb_rsp,
  // Pins from the partner
  input  wire logic                   capture_input_pin,
  input  wire logic                   external_count_pin,
  // Waveform outputs
  output      tmcc_pkg::tmcc_wave_s    wave
);

  // ==========================================================================
  // Elaboration check
  if (PSC_W != 10) begin : g_psc_chk
    $error("PSC_W must be 10 to match the divisor taps");
  end

  tmcc_pkg::tmcc_state_s s_r;    // Registered state
  tmcc_pkg::tmcc_state_s s_nxt;  // Next state

  // ==========================================================================
  // Functions

  // Class of counting sequence for a mode code
  function automatic tmcc_pkg::tmcc_kind_e kind_of(input logic [3:0] m);
    unique case (m)
      4'h0, 4'hd:                return tmcc_pkg::K_NORMAL;  // Reserved runs as normal
      4'h4, 4'hc:                return tmcc_pkg::K_CTC;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: return tmcc_pkg::K_FAST;
      4'h8, 4'h9:                return tmcc_pkg::K_PFC;
      default:                   return tmcc_pkg::K_PC;      // 1, 2, 3, 10, 11
    endcase
  endfunction : kind_of

  // TOP value for a mode code
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a,
                                         input logic [15:0] c);
    unique case (m)
      4'h1, 4'h5:             return tmcc_pkg::TOP_8B;
      4'h2, 4'h6:             return tmcc_pkg::TOP_9B;
      4'h3, 4'h7:             return tmcc_pkg::TOP_10B;
      4'h4, 4'h9, 4'hb, 4'hf: return a;
      4'h8, 4'ha, 4'hc, 4'he: return c;
      default:                return tmcc_pkg::CNT_MAX;
    endcase
  endfunction : top_of

  // True when the capture register defines TOP
  function automatic logic capt_is_top(input logic [3:0] m);
    return (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
  endfunction : capt_is_top

  // Prescaler tap for a clock source code
  function automatic logic psc_tap(input logic [2:0] cs, input logic [9:0] p);
    unique case (cs)
      tmcc_pkg::CS_DIV1:    return 1'b1;
      tmcc_pkg::CS_DIV8:    return &p[2:0];
      tmcc_pkg::CS_DIV64:   return &p[5:0];
      tmcc_pkg::CS_DIV256:  return &p[7:0];
      tmcc_pkg::CS_DIV1024: return &p[9:0];
      default:              return 1'b0;
    endcase
  endfunction : psc_tap

  // New output level on a compare match
  function automatic logic on_match(input logic old, input logic [1:0] act,
                                    input tmcc_pkg::tmcc_kind_e k, input logic down,
                                    input logic chan_a, input logic [3:0] m);
    logic pwm;
    pwm = (k == tmcc_pkg::K_FAST) || (k == tmcc_pkg::K_PC) || (k == tmcc_pkg::K_PFC);
    unique case (act)
      tmcc_pkg::ACT_TGL: begin
        // PWM toggles only channel A in its A-as-TOP or capture-as-TOP modes
        if (!pwm || (chan_a && m[3] && (m != tmcc_pkg::WGM_RSVD))) return ~old;
        else return old;
      end
      tmcc_pkg::ACT_CLR: return (k != tmcc_pkg::K_FAST && pwm) ? down : 1'b0;
      tmcc_pkg::ACT_SET: return (k != tmcc_pkg::K_FAST && pwm) ? ~down : 1'b1;
      default:           return old;
    endcase
  endfunction : on_match

  // ==========================================================================
  // Decoded views of the control registers
  logic [3:0]           wgm;        // waveform_mode_sel
  logic [2:0]           cs;         // clock_source_sel
  logic [1:0]           act_a;      // output_action_sel for A
  logic [1:0]           act_b;      // output_action_sel for B
  tmcc_pkg::tmcc_kind_e kind;       // Sequence class
  logic [15:0]          top;        // Current TOP
  logic                 pwm_mode;   // Any PWM class
  logic                 tick;       // Timer clock enable
  logic                 cap_src;    // Capture input after optional filter
  logic                 cap_evt;    // Qualified pin capture
  logic                 ext_edge;   // Selected edge on the count pin
  logic                 wr_acc;     // APB write access phase
  logic                 unmapped;   // Address outside the map
  logic [5:0]           flag_set;   // Hardware flag sets
  logic [5:0]           flag_clr;   // Software flag clears
  logic [31:0]          rd_mux;     // Read data selected by address

  assign wgm      = {s_r.ctrl_b[tmcc_pkg::CB_WGMH_LSB +: 2], s_r.ctrl_a[1:0]};
  assign cs       = s_r.ctrl_b[2:0];
  assign act_a    = s_r.ctrl_a[tmcc_pkg::CA_ACT_A_LSB +: 2];
  assign act_b    = s_r.ctrl_a[tmcc_pkg::CA_ACT_B_LSB +: 2];
  assign kind     = kind_of(wgm);
  assign top      = top_of(wgm, s_r.cmp_a, s_r.capt);
  assign pwm_mode = (kind == tmcc_pkg::K_FAST) || (kind == tmcc_pkg::K_PC) ||
                    (kind == tmcc_pkg::K_PFC);

  // Count pin edges are taken straight from the pin, whatever drives it
  assign ext_edge = (cs == tmcc_pkg::CS_EXT_RIS) ? (external_count_pin & ~s_r.ext_prev) :
                    (s_r.ext_prev & ~external_count_pin);
  assign tick     = cs[2] & cs[1] ? ext_edge : psc_tap(cs, s_r.psc);

  // Filtered or raw capture input, then edge qualify
  assign cap_src  = s_r.ctrl_b[tmcc_pkg::CB_FILT_BIT] ? s_r.cap_filt : capture_input_pin;
  assign cap_evt  = !capt_is_top(wgm) &&
                    (s_r.ctrl_b[tmcc_pkg::CB_EDGE_BIT] ? (cap_src & ~s_r.cap_prev) :
                                                         (~cap_src & s_r.cap_prev));

  // APB decode; every access completes without wait states
  assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign unmapped = (apb_req.paddr[1:0] != 2'h0) || (apb_req.paddr[7:5] != 3'h0);
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & unmapped;
  assign apb_rsp.prdata  = s_r.prdata;

  // Outputs: the action code of zero disconnects the pin
  assign wave.wave_out_a    = s_r.wave_a;
  assign wave.wave_out_b    = s_r.wave_b;
  assign wave.wave_out_a_en = (act_a != tmcc_pkg::ACT_OFF);
  assign wave.wave_out_b_en = (act_b != tmcc_pkg::ACT_OFF);

  // ==========================================================================
  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (apb_req.paddr)
      tmcc_pkg::OFS_CTRL_A: rd_mux[7:0]  = {s_r.ctrl_a[7:4], 2'h0, s_r.ctrl_a[1:0]};
      tmcc_pkg::OFS_CTRL_B: rd_mux[7:0]  = s_r.ctrl_b;  // Bit 5 is held at zero
      tmcc_pkg::OFS_FORCE:  rd_mux[7:0]  = 8'h00;
      tmcc_pkg::OFS_COUNT:  rd_mux[15:0] = s_r.cnt;
      tmcc_pkg::OFS_CMP_A:  rd_mux[15:0] = s_r.cmp_a_buf;
      tmcc_pkg::OFS_CMP_B:  rd_mux[15:0] = s_r.cmp_b_buf;
      tmcc_pkg::OFS_CAPT:   rd_mux[15:0] = s_r.capt;
      tmcc_pkg::OFS_FLAGS:  rd_mux[5:0]  = s_r.flags;
      default:              rd_mux       = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic at_top;
    logic hit_a;
    logic hit_b;
    s_nxt    = s_r;
    flag_set = 6'h00;
    flag_clr = 6'h00;
    at_top   = (s_r.cnt >= top);
    hit_a    = tick && (s_r.cnt == s_r.cmp_a);
    hit_b    = tick && (s_r.cnt == s_r.cmp_b);

    // Free-running prescaler and pin history
    s_nxt.psc      = s_r.psc + 10'h001;
    s_nxt.ext_prev = external_count_pin;
    s_nxt.cap_prev = cap_src;

    // Four equal samples move the filtered level
    s_nxt.cap_shift = {s_r.cap_shift[2:0], capture_input_pin};
    if (s_r.cap_shift == 4'hf) begin
      s_nxt.cap_filt = 1'b1;
    end else if (s_r.cap_shift == 4'h0) begin
      s_nxt.cap_filt = 1'b0;
    end

    // Immediate modes use the written compare values directly
    if (kind == tmcc_pkg::K_NORMAL || kind == tmcc_pkg::K_CTC) begin
      s_nxt.cmp_a = s_r.cmp_a_buf;
      s_nxt.cmp_b = s_r.cmp_b_buf;
    end

    // Compare matches on the timer clock
    if (hit_a) begin
      flag_set[tmcc_pkg::FL_CMP_A] = 1'b1;
      s_nxt.wave_a = on_match(s_r.wave_a, act_a, kind, s_r.down, 1'b1, wgm);
    end
    if (hit_b) begin
      flag_set[tmcc_pkg::FL_CMP_B] = 1'b1;
      s_nxt.wave_b = on_match(s_r.wave_b, act_b, kind, s_r.down, 1'b0, wgm);
    end

    // Counting sequence
    if (tick) begin
      unique case (kind)
        tmcc_pkg::K_NORMAL: begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
          if (s_r.cnt == tmcc_pkg::CNT_MAX) flag_set[tmcc_pkg::FL_OVF] = 1'b1;
        end
        tmcc_pkg::K_CTC: begin
          s_nxt.cnt = at_top ? 16'h0000 : s_r.cnt + 16'h0001;
          if (s_r.cnt == tmcc_pkg::CNT_MAX) flag_set[tmcc_pkg::FL_OVF] = 1'b1;
        end
        tmcc_pkg::K_FAST: begin
          if (at_top) begin
            s_nxt.cnt = 16'h0000;
            s_nxt.cmp_a = s_r.cmp_a_buf;
            s_nxt.cmp_b = s_r.cmp_b_buf;
            flag_set[tmcc_pkg::FL_OVF] = 1'b1;
            // Non-inverting set, inverting clear at TOP
            if (act_a[1]) s_nxt.wave_a = ~act_a[0];
            if (act_b[1]) s_nxt.wave_b = ~act_b[0];
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end
        default: begin  // Phase correct and phase/frequency correct
          if (!s_r.down) begin
            if (at_top) begin
              s_nxt.down = 1'b1;
              s_nxt.cnt  = s_r.cnt - 16'h0001;
              if (kind == tmcc_pkg::K_PC) begin
                s_nxt.cmp_a = s_r.cmp_a_buf;
                s_nxt.cmp_b = s_r.cmp_b_buf;
              end
            end else begin
              s_nxt.cnt = s_r.cnt + 16'h0001;
            end
          end else if (s_r.cnt == 16'h0000) begin
            s_nxt.down = 1'b0;
            s_nxt.cnt  = 16'h0001;
            flag_set[tmcc_pkg::FL_OVF] = 1'b1;
            if (kind == tmcc_pkg::K_PFC) begin
              s_nxt.cmp_a = s_r.cmp_a_buf;
              s_nxt.cmp_b = s_r.cmp_b_buf;
            end
          end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
          end
        end
      endcase
      // Capture register as TOP marks the turn with the capture flag
      if (capt_is_top(wgm) && (s_r.cnt == top)) flag_set[tmcc_pkg::FL_CAPT] = 1'b1;
    end
    if (!pwm_mode) s_nxt.down = 1'b0;

    // Pin capture
    if (cap_evt) begin
      s_nxt.capt = s_r.cnt;
      flag_set[tmcc_pkg::FL_CAPT] = 1'b1;
    end

    // Register writes; a counter write overrides the count
    if (wr_acc) begin
      unique case (apb_req.paddr)
        tmcc_pkg::OFS_CTRL_A: s_nxt.ctrl_a = {apb_req.pwdata[7:4], 2'h0, apb_req.pwdata[1:0]};
        tmcc_pkg::OFS_CTRL_B: begin
          s_nxt.ctrl_b = apb_req.pwdata[7:0];
          s_nxt.ctrl_b[tmcc_pkg::CB_RSVD_BIT] = 1'b0;
        end
        tmcc_pkg::OFS_FORCE: begin
          // Strobes in non-PWM modes only; no flag and no counter clear
          if (!pwm_mode && apb_req.pwdata[tmcc_pkg::FC_A_BIT]) begin
            s_nxt.wave_a = on_match(s_r.wave_a, act_a, kind, 1'b0, 1'b1, wgm);
          end
          if (!pwm_mode && apb_req.pwdata[tmcc_pkg::FC_B_BIT]) begin
            s_nxt.wave_b = on_match(s_r.wave_b, act_b, kind, 1'b0, 1'b0, wgm);
          end
        end
        tmcc_pkg::OFS_COUNT: s_nxt.cnt       = apb_req.pwdata[15:0];
        tmcc_pkg::OFS_CMP_A: s_nxt.cmp_a_buf = apb_req.pwdata[15:0];
        tmcc_pkg::OFS_CMP_B: s_nxt.cmp_b_buf = apb_req.pwdata[15:0];
        tmcc_pkg::OFS_CAPT:  s_nxt.capt      = apb_req.pwdata[15:0];
        tmcc_pkg::OFS_FLAGS: flag_clr        = apb_req.pwdata[5:0];
        default: ;
      endcase
    end

    // A set in the clearing cycle wins
    s_nxt.flags = ((s_r.flags & ~flag_clr) | flag_set) & 6'h27;

    // Read data is captured in the setup cycle
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      s_nxt.prdata = rd_mux;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Checks
  sequence seq_stop;
    cs == tmcc_pkg::CS_STOP && !wr_acc;
  endsequence

  sequence seq_fast_top;
    tick && kind == tmcc_pkg::K_FAST && s_r.cnt == top && !wr_acc;
  endsequence

  sequence seq_force_a;
    wr_acc && apb_req.paddr == tmcc_pkg::OFS_FORCE && apb_req.pwdata[tmcc_pkg::FC_A_BIT];
  endsequence

  a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    seq_stop |=> s_r.cnt == $past(s_r.cnt))
    else $error("Counter moved with no clock source");

  a_normal_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    tick && wgm == 4'h0 && s_r.cnt == tmcc_pkg::CNT_MAX && !wr_acc
    |=> s_r.cnt == 16'h0000 && s_r.flags[tmcc_pkg::FL_OVF])
    else $error("Normal mode did not wrap with overflow");

  a_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    tick && wgm == 4'h4 && s_r.cnt == s_r.cmp_a && !wr_acc |=> s_r.cnt == 16'h0000)
    else $error("Clear-on-match mode did not clear at compare A");

  a_fast_top: assert property (@(posedge pclk) disable iff (!presetn)
    seq_fast_top |=> s_r.cnt == 16'h0000 && s_r.flags[tmcc_pkg::FL_OVF] &&
                     s_r.cmp_a == $past(s_r.cmp_a_buf))
    else $error("Fast mode TOP did not restart, flag and reload");

  a_pc_bottom: assert property (@(posedge pclk) disable iff (!presetn)
    tick && kind == tmcc_pkg::K_PC && s_r.down && s_r.cnt == 16'h0000 && !wr_acc
    |=> !s_r.down && s_r.cnt == 16'h0001 && s_r.flags[tmcc_pkg::FL_OVF])
    else $error("Phase-correct turn at bottom wrong");

  a_filter_four: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(s_r.cap_filt) |-> $past(s_r.cap_shift) == {4{s_r.cap_filt}})
    else $error("Filter changed without four equal samples");

  a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt && !wr_acc |=> s_r.capt == $past(s_r.cnt) && s_r.flags[tmcc_pkg::FL_CAPT])
    else $error("Capture did not copy counter and flag");

  a_capt_top_off: assert property (@(posedge pclk) disable iff (!presetn)
    capt_is_top(wgm) |-> !cap_evt)
    else $error("Pin capture while capture register is TOP");

  a_ext_rise: assert property (@(posedge pclk) disable iff (!presetn)
    cs == tmcc_pkg::CS_EXT_RIS && $rose(external_count_pin) |-> tick)
    else $error("Rising count pin edge not counted");

  a_force_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_force_a and (!tick && !cap_evt)) |=> s_r.cnt == $past(s_r.cnt) &&
    s_r.flags[tmcc_pkg::FL_CMP_A] == $past(s_r.flags[tmcc_pkg::FL_CMP_A]))
    else $error("Forced match changed counter or flag");

  a_force_pwm_off: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_force_a and (pwm_mode && !tick)) |=> s_r.wave_a == $past(s_r.wave_a))
    else $error("Force strobe acted in a PWM mode");

  a_force_set: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_force_a and (!pwm_mode && act_a == tmcc_pkg::ACT_SET)) |=> s_r.wave_a)
    else $error("Forced match with set action did not set");

  a_force_read0: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
    apb_req.paddr == tmcc_pkg::OFS_FORCE |=> apb_rsp.prdata == 32'h0000_0000)
    else $error("Force register read not zero");

endmodule : tmcc_timer16_ctl

// [verif/timer16_mode_clock_capture_ctl_test.sv]
// Self-checking bench of the 16-bit timer control block
`timescale 1ns/1ps
module timer16_mode_clock_capture_ctl_test;
  logic                    pclk    = 1'b0;  // Bus clock
  logic                    presetn = 1'b0;  // Reset, active low
  tmcc_pkg::tmcc_apb_req_s req     = '0;    // APB request
  tmcc_pkg::tmcc_apb_rsp_s rsp;             // APB answer
  tmcc_pkg::tmcc_wave_s    wave;            // Waveform outputs
  logic                    cap, ext;        // Pins from the model
  int                      num_errors  = 0;
  int                      check_count = 0;
  logic [31:0]             v;               // Scratch read value
  logic                    err;             // Error answer of the last transfer
  tmcc_timer16_ctl i_tmcc_timer16_ctl (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .capture_input_pin(cap), .external_count_pin(ext),
    .wave(wave));
  tmcc_pin_model i_tmcc_pin_model (.pclk(pclk), .capture_input_pin(cap),
    .external_count_pin(ext));
  // ==========
  // Clock, 40 ns period
  initial forever #20 pclk = ~pclk;
  // Word compare, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk) req.penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (rsp.pready === 1'b1) break;
    end
    v = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // ==========
  // Reserved, strobe and unmapped places read zero
  task automatic t_regs();
    wr(tmcc_pkg::OFS_CTRL_B, 32'h20);
    rd(tmcc_pkg::OFS_CTRL_B); chk(v, 32'h0);
    wr(tmcc_pkg::OFS_FORCE, 32'hc0);
    rd(tmcc_pkg::OFS_FORCE); chk(v, 32'h0);
    rd(8'h20); chk(v, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test regs done");
  endtask : t_regs
  // Normal mode runs past MAX, then stops on code 0
  task automatic t_count();
    // Upper write bits are dropped; three undivided ticks pass while the
    // stop code is on its way: fffe, ffff, 0000, 0001
    wr(tmcc_pkg::OFS_COUNT, 32'h5a5a_fffe);
    wr(tmcc_pkg::OFS_CTRL_B, 32'h01);
    wr(tmcc_pkg::OFS_CTRL_B, 32'h00);
    rd(tmcc_pkg::OFS_FLAGS); chk(v & 32'h1, 32'h1);
    rd(tmcc_pkg::OFS_COUNT); chk(v, 32'h1);
    repeat (10) @(posedge pclk);
    rd(tmcc_pkg::OFS_COUNT); chk(v, 32'h1);
    wr(tmcc_pkg::OFS_FLAGS, 32'h3f);
    $display("test count done");
  endtask : t_count
  // Both external edge codes count whole pin pulses
  task automatic t_ext();
    for (int cs = 6; cs < 8; cs++) begin
      wr(tmcc_pkg::OFS_COUNT, 32'h0);
      wr(tmcc_pkg::OFS_CTRL_B, 32'(cs));
      i_tmcc_pin_model.count_pulses(3);
      wr(tmcc_pkg::OFS_CTRL_B, 32'h0);
      rd(tmcc_pkg::OFS_COUNT); chk(v, 32'h3);
    end
    $display("test ext done");
  endtask : t_ext
  // Filtered rising capture, wrong edge, then capture as TOP
  task automatic t_capt();
    // Compare flags left by the counting tests are cleared first
    wr(tmcc_pkg::OFS_FLAGS, 32'h3f);
    wr(tmcc_pkg::OFS_COUNT, 32'h1234);
    wr(tmcc_pkg::OFS_CTRL_B, 32'hc0);
    i_tmcc_pin_model.capture_level(1'b1);
    rd(tmcc_pkg::OFS_CAPT); chk(v, 32'h1234);
    rd(tmcc_pkg::OFS_FLAGS); chk(v, 32'h20);
    wr(tmcc_pkg::OFS_FLAGS, 32'h20);
    i_tmcc_pin_model.capture_level(1'b0);
    rd(tmcc_pkg::OFS_FLAGS); chk(v, 32'h0);
    wr(tmcc_pkg::OFS_CTRL_B, 32'h18);
    i_tmcc_pin_model.capture_level(1'b1);
    i_tmcc_pin_model.capture_level(1'b0);
    rd(tmcc_pkg::OFS_FLAGS); chk(v, 32'h0);
    wr(tmcc_pkg::OFS_CTRL_B, 32'h0);
    $display("test capt done");
  endtask : t_capt
  // Force strobes: set, toggle, then ignored in a PWM mode
  task automatic t_force();
    wr(tmcc_pkg::OFS_CTRL_A, 32'hc0);
    wr(tmcc_pkg::OFS_FORCE, 32'h80);
    // Wave register loads at the write edge; look once it has settled
    @(negedge pclk);
    chk({31'h0, wave.wave_out_a}, 32'h1);
    chk({29'h0, wave.wave_out_a_en, wave.wave_out_b_en, wave.wave_out_b}, 32'h4);
    rd(tmcc_pkg::OFS_FLAGS); chk(v, 32'h0);
    wr(tmcc_pkg::OFS_CTRL_A, 32'h40);
    wr(tmcc_pkg::OFS_FORCE, 32'h80);
    @(negedge pclk);
    chk({31'h0, wave.wave_out_a}, 32'h0);
    wr(tmcc_pkg::OFS_CTRL_A, 32'hc1);
    wr(tmcc_pkg::OFS_FORCE, 32'h80);
    @(negedge pclk);
    chk({31'h0, wave.wave_out_a}, 32'h0);
    // Well-behaved software leaves the strobes at zero in a PWM mode
    wr(tmcc_pkg::OFS_FORCE, 32'h0);
    @(negedge pclk);
    chk({31'h0, wave.wave_out_a}, 32'h0);
    $display("test force done");
  endtask : t_force
  // Counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs(); t_count(); t_ext(); t_capt(); t_force();
    give_verdict();
  end
  // Watchdog, far beyond the roughly 200 cycles needed
  initial begin
    #800000;
    num_errors++;
    give_verdict();
  end
endmodule : timer16_mode_clock_capture_ctl_test

// [verif/tmcc_pin_model.sv]
// Far-side pin model: capture input and external count pin
`timescale 1ns/1ps
module tmcc_pin_model (
  // Clock
  input  wire logic pclk,
  // Pins toward the timer
  output logic      capture_input_pin,
  output logic      external_count_pin
);
  // ==========
  // Pins idle low from time zero
  initial begin
    capture_input_pin  = 1'b0;
    external_count_pin = 1'b0;
  end
  // Whole pulses, each level held so the pin sampler sees it
  task automatic count_pulses(input int n);
    repeat (n) begin
      @(posedge pclk) external_count_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      external_count_pin <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : count_pulses
  // New capture level, then wait out the filter delay
  task automatic capture_level(input logic v);
    @(posedge pclk) capture_input_pin <= v;
    repeat (8) @(posedge pclk);
  endtask : capture_level
endmodule : tmcc_pin_model
